// ===== tw_target.sv
// two-wire target front end: byte memory plus companion register bank
// assumes scl, sda and select pins are asynchronous; sda pad is open drain
`default_nettype none
module tw_target #(
  parameter int MEM_DEPTH = 512
) (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       select_pin_low_in,
  input  wire logic       select_pin_high_in
);
  localparam int AW = $clog2(MEM_DEPTH);
  typedef struct packed {
    logic [1:0]                    scl_s;
    logic                          scl_q;
    logic [1:0]                    sda_s;
    logic                          sda_q;
    logic [1:0]                    sel_s0;
    logic [1:0]                    sel_s1;
    tw_pkg::tw_state_e             st;
    tw_pkg::tw_state_e             ret;
    logic [7:0]                    shreg;
    logic [3:0]                    bitcnt;
    logic                          ack_ph;
    logic                          ack_ok;
    logic                          sda_oe;
    logic                          is_comp;
    logic [7:0]                    hi;
    logic [AW-1:0]                 mem_ptr;
    logic [3:0]                    comp_ptr;
    logic [7:0]                    tx;
    logic [tw_pkg::COMP_NUM-1:0][7:0] comp;
    logic [MEM_DEPTH-1:0][7:0]     mem;
  } tw_core_s;

  tw_core_s          r_reg;
  tw_core_s          r_next;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_c;
  logic              stop_c;
  logic              byte_done;
  logic [7:0]        rx_byte;
  logic              wr_evt;
  logic              dev_evt;
  logic              sel_ok;
  logic [1:0]        wp;
  logic              prot;
  logic              rd_load;
  logic              push_valid;
  logic              push_ready;
  logic              pop_valid;
  logic              pop_ready;
  tw_pkg::tw_wword_s push_word;
  tw_pkg::tw_wword_s pop_word;

  // edges come from the second sync stage against its delayed copy
  assign scl_rise  = r_reg.scl_s[1] && !r_reg.scl_q;
  assign scl_fall  = !r_reg.scl_s[1] && r_reg.scl_q;
  assign start_c   = r_reg.scl_s[1] && r_reg.scl_q &&
                     !r_reg.sda_s[1] && r_reg.sda_q;
  assign stop_c    = r_reg.scl_s[1] && r_reg.scl_q &&
                     r_reg.sda_s[1] && !r_reg.sda_q;
  assign rx_byte   = {r_reg.shreg[6:0], r_reg.sda_s[1]};
  assign byte_done = scl_rise && (r_reg.bitcnt == 4'h7) && !start_c;
  assign dev_evt   = byte_done && (r_reg.st == tw_pkg::S_DEV);
  assign wr_evt    = byte_done && (r_reg.st == tw_pkg::S_WDATA);
  assign sel_ok    = (rx_byte[tw_pkg::SEL_LSB+1:tw_pkg::SEL_LSB] ==
                      r_reg.sel_s1);
  assign wp = {r_reg.comp[tw_pkg::PROT_REG][tw_pkg::PROT_HI],
               r_reg.comp[tw_pkg::PROT_REG][tw_pkg::PROT_LO]};

  // protection covers the low end of the array
  always_comb begin
    case (wp)
      tw_pkg::PROT_NONE: prot = 1'b0;
      tw_pkg::PROT_QTR:  prot = (r_reg.mem_ptr[AW-1:AW-2] == 2'h0);
      tw_pkg::PROT_HALF: prot = !r_reg.mem_ptr[AW-1];
      tw_pkg::PROT_ALL:  prot = 1'b1;
      default:           prot = 1'b1;
    endcase
  end

  assign rd_load = scl_fall && !start_c &&
                   (((r_reg.st == tw_pkg::S_ACK) && r_reg.ack_ph &&
                     (r_reg.ret == tw_pkg::S_RDATA)) ||
                    (r_reg.st == tw_pkg::S_RACK));
  // a full fifo refuses the byte rather than losing it
  assign push_valid = wr_evt && !r_reg.is_comp && !prot;
  assign push_word  = '{addr: tw_pkg::MAX_AW'(r_reg.mem_ptr), data: rx_byte};
  // drain pauses while a read byte is fetched from the array
  assign pop_ready  = !rd_load;
  assign sda_out    = 1'b0;
  assign sda_oe_out = r_reg.sda_oe;

  tw_fifo #(
    .W     ($bits(tw_pkg::tw_wword_s)),
    .DEPTH (tw_pkg::FIFO_DEPTH)
  ) u_wfifo (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_word),
    .out_valid_out (pop_valid),
    .out_ready_in  (pop_ready),
    .out_data_out  (pop_word)
  );

  always_comb begin
    r_next        = r_reg;
    r_next.scl_s  = {r_reg.scl_s[0], scl_in};
    r_next.scl_q  = r_reg.scl_s[1];
    r_next.sda_s  = {r_reg.sda_s[0], sda_in};
    r_next.sda_q  = r_reg.sda_s[1];
    r_next.sel_s0 = {select_pin_high_in, select_pin_low_in};
    r_next.sel_s1 = r_reg.sel_s0;
    if (pop_valid && pop_ready) begin
      r_next.mem[pop_word.addr[AW-1:0]] = pop_word.data;
    end
    if (start_c) begin
      r_next.st     = tw_pkg::S_DEV;
      r_next.bitcnt = 4'h0;
      r_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      r_next.st     = tw_pkg::S_IDLE;
      r_next.sda_oe = 1'b0;
    end else begin
      case (r_reg.st)
        tw_pkg::S_DEV, tw_pkg::S_AHI, tw_pkg::S_ALO,
        tw_pkg::S_WDATA: begin
          if (scl_rise) begin
            r_next.shreg  = rx_byte;
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          if (byte_done) begin
            r_next.st     = tw_pkg::S_ACK;
            r_next.ack_ph = 1'b0;
            r_next.ack_ok = 1'b1;
            case (r_reg.st)
              tw_pkg::S_DEV: begin
                r_next.is_comp = (rx_byte[7:4] == tw_pkg::COMP_ID);
                if (rx_byte[0]) begin
                  r_next.ret = tw_pkg::S_RDATA;
                end else if (rx_byte[7:4] == tw_pkg::COMP_ID) begin
                  r_next.ret = tw_pkg::S_ALO;
                end else begin
                  r_next.ret = tw_pkg::S_AHI;
                end
                if (!sel_ok || ((rx_byte[7:4] != tw_pkg::MEM_ID) &&
                                (rx_byte[7:4] != tw_pkg::COMP_ID))) begin
                  r_next.st = tw_pkg::S_IDLE;
                end
              end
              tw_pkg::S_AHI: begin
                r_next.hi  = rx_byte;
                r_next.ret = tw_pkg::S_ALO;
              end
              tw_pkg::S_ALO: begin
                r_next.ret = tw_pkg::S_WDATA;
                if (r_reg.is_comp) begin
                  r_next.comp_ptr = rx_byte[3:0];
                end else begin
                  r_next.mem_ptr = AW'({r_reg.hi, rx_byte});
                end
              end
              default: begin
                r_next.ret = tw_pkg::S_WDATA;
                if (r_reg.is_comp) begin
                  r_next.comp[r_reg.comp_ptr] = rx_byte;
                  r_next.comp_ptr = r_reg.comp_ptr + 4'h1;
                end else begin
                  r_next.ack_ok  = push_valid && push_ready;
                  r_next.mem_ptr = r_reg.mem_ptr + 1'b1;
                end
              end
            endcase
          end
        end
        tw_pkg::S_ACK: begin
          if (scl_fall && !r_reg.ack_ph) begin
            r_next.ack_ph = 1'b1;
            r_next.sda_oe = r_reg.ack_ok;
          end else if (scl_fall) begin
            r_next.st     = r_reg.ret;
            r_next.bitcnt = 4'h0;
            r_next.sda_oe = 1'b0;
          end
        end
        tw_pkg::S_RDATA: begin
          if (scl_rise) begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          if (scl_fall && (r_reg.bitcnt == 4'h8)) begin
            r_next.sda_oe = 1'b0;
            r_next.st     = tw_pkg::S_RACK;
            if (r_reg.is_comp) begin
              r_next.comp_ptr = r_reg.comp_ptr + 4'h1;
            end else begin
              r_next.mem_ptr = r_reg.mem_ptr + 1'b1;
            end
          end else if (scl_fall) begin
            r_next.sda_oe = !r_reg.tx[7];
            r_next.tx     = {r_reg.tx[6:0], 1'b0};
          end
        end
        tw_pkg::S_RACK: begin
          // master nack ends the burst
          if (scl_rise && r_reg.sda_s[1]) begin
            r_next.st = tw_pkg::S_IDLE;
          end
        end
        default: begin
          r_next.sda_oe = 1'b0;
        end
      endcase
      if (rd_load) begin
        r_next.st     = tw_pkg::S_RDATA;
        r_next.bitcnt = 4'h0;
        if (r_reg.is_comp) begin
          r_next.sda_oe = !r_reg.comp[r_reg.comp_ptr][7];
          r_next.tx     = {r_reg.comp[r_reg.comp_ptr][6:0], 1'b0};
        end else begin
          r_next.sda_oe = !r_reg.mem[r_reg.mem_ptr][7];
          r_next.tx     = {r_reg.mem[r_reg.mem_ptr][6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_reg       <= '0;
      r_reg.scl_s <= 2'h3;
      r_reg.scl_q <= 1'b1;
      r_reg.sda_s <= 2'h3;
      r_reg.sda_q <= 1'b1;
      r_reg.comp  <= {tw_pkg::COMP_NUM{tw_pkg::COMP_RST}};
    end else begin
      r_reg <= r_next;
    end
  end

  property p_sel_mismatch;
    @(posedge clk_in) disable iff (!rstn_in)
    (dev_evt && !start_c && !stop_c && !sel_ok) |=> (r_reg.st == tw_pkg::S_IDLE);
  endproperty
  a_sel_mismatch: assert property (p_sel_mismatch)
    else $error("address answered with wrong select pins");

  property p_sda_on_fall;
    @(posedge clk_in) disable iff (!rstn_in)
    (r_reg.sda_oe != $past(r_reg.sda_oe)) |->
      $past(scl_fall || start_c || stop_c);
  endproperty
  a_sda_on_fall: assert property (p_sda_on_fall)
    else $error("sda drive changed away from a falling scl");

  property p_comp_id;
    @(posedge clk_in) disable iff (!rstn_in)
    (dev_evt && !stop_c && rx_byte[7:4] == tw_pkg::COMP_ID) |=> r_reg.is_comp;
  endproperty
  a_comp_id: assert property (p_comp_id)
    else $error("companion identifier not taken");

  property p_ptr_kept;
    @(posedge clk_in) disable iff (!rstn_in)
    r_reg.is_comp |=> $stable(r_reg.mem_ptr);
  endproperty
  a_ptr_kept: assert property (p_ptr_kept)
    else $error("memory pointer moved during companion access");

  property p_comp_write;
    @(posedge clk_in) disable iff (!rstn_in)
    (wr_evt && !start_c && !stop_c && r_reg.is_comp) |=>
      (r_reg.comp[$past(r_reg.comp_ptr)] == $past(rx_byte));
  endproperty
  a_comp_write: assert property (p_comp_write)
    else $error("companion register not written");

  property p_two_byte;
    @(posedge clk_in) disable iff (!rstn_in)
    (dev_evt && !stop_c && !rx_byte[0] && rx_byte[7:4] == tw_pkg::MEM_ID)
      |=> (r_reg.ret == tw_pkg::S_AHI);
  endproperty
  a_two_byte: assert property (p_two_byte)
    else $error("memory write skipped the high address byte");

  property p_drain;
    @(posedge clk_in) disable iff (!rstn_in)
    push_valid |-> ##[1:40] !pop_valid;
  endproperty
  a_drain: assert property (p_drain)
    else $error("write data not committed in time");

  property p_full_prot;
    @(posedge clk_in) disable iff (!rstn_in)
    (wr_evt && !start_c && !stop_c && !r_reg.is_comp &&
     wp == tw_pkg::PROT_ALL) |=> !r_reg.ack_ok;
  endproperty
  a_full_prot: assert property (p_full_prot)
    else $error("write acknowledged under full protection");

  // judged where bytes reach the array, independent of the queue side
  property p_prot_nopush;
    @(posedge clk_in) disable iff (!rstn_in)
    (pop_valid && pop_ready) |->
      !((wp == tw_pkg::PROT_ALL) ||
        ((wp == tw_pkg::PROT_HALF) && (pop_word.addr < MEM_DEPTH / 2)) ||
        ((wp == tw_pkg::PROT_QTR) && (pop_word.addr < MEM_DEPTH / 4)));
  endproperty
  a_prot_nopush: assert property (p_prot_nopush)
    else $error("protected byte committed to the array");

  property p_ptr_step;
    @(posedge clk_in) disable iff (!rstn_in)
    (r_reg.st == tw_pkg::S_RDATA && scl_fall && !start_c && !stop_c &&
     r_reg.bitcnt == 4'h8 && !r_reg.is_comp) |=>
      (r_reg.mem_ptr == AW'($past(r_reg.mem_ptr) + 1'b1));
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("memory pointer did not step after a read byte");
endmodule
`default_nettype wire

// ===== tw_pkg.sv
// shared constants and carriers for the two-wire memory companion front end
// assumes a single core clock domain; the serial pins are sampled by it
`default_nettype none
package tw_pkg;
  // device identifiers; values are arbitrary
  localparam logic [3:0] MEM_ID    = 4'hA;
  localparam logic [3:0] COMP_ID   = 4'hD;
  // position of the select bits inside the address byte
  localparam int         SEL_LSB   = 1;
  // companion register holding the protection field
  localparam logic [3:0] PROT_REG  = 4'hB;
  localparam int         PROT_LO   = 2;
  localparam int         PROT_HI   = 3;
  localparam logic [7:0] COMP_RST  = 8'h00;
  localparam int         COMP_NUM  = 16;
  localparam int         MAX_AW    = 15;
  localparam int         FIFO_DEPTH = 16;
  localparam logic [1:0] PROT_NONE = 2'h0;
  localparam logic [1:0] PROT_QTR  = 2'h1;
  localparam logic [1:0] PROT_HALF = 2'h2;
  localparam logic [1:0] PROT_ALL  = 2'h3;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_DEV   = 4'h1,
    S_AHI   = 4'h2,
    S_ALO   = 4'h3,
    S_WDATA = 4'h4,
    S_ACK   = 4'h5,
    S_RDATA = 4'h6,
    S_RACK  = 4'h7
  } tw_state_e;

  typedef struct packed {
    logic [MAX_AW-1:0] addr;
    logic [7:0]        data;
  } tw_wword_s;
endpackage
`default_nettype wire

// ===== tw_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes producer and consumer share clk_in
`default_nettype none
module tw_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } tw_fifo_s;
  tw_fifo_s r_reg;
  tw_fifo_s r_next;
  logic     full;
  logic     empty;

  // extra pointer bit tells full from empty
  assign empty = (r_reg.wp == r_reg.rp);
  assign full  = (r_reg.wp[AW] != r_reg.rp[AW]) &&
                 (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = r_reg.mem[r_reg.rp[AW-1:0]];

  always_comb begin
    r_next = r_reg;
    if (in_valid_in && !full) begin
      r_next.mem[r_reg.wp[AW-1:0]] = in_data_in;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (out_ready_in && !empty) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule
`default_nettype wire

// ===== tw_host.sv
// two-wire bus master model standing in for the host processor
// assumes the bench forms the open-drain wire with a pull-up
`default_nettype none
module tw_host (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // clk cycles per quarter bit; 4 is the fast bench rate, 40 stays under 1 MHz
  int qlen = 4;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic quarter();
    repeat (qlen) @(posedge clk_in);
  endtask
  // works from idle and as a repeated start after an acked byte
  task automatic start_bit();
    sda_low_out <= 1'b0;
    quarter();
    scl_out <= 1'b1;
    quarter();
    sda_low_out <= 1'b1;
    quarter();
    scl_out <= 1'b0;
    quarter();
  endtask
  task automatic stop_bit();
    sda_low_out <= 1'b1;
    quarter();
    scl_out <= 1'b1;
    quarter();
    sda_low_out <= 1'b0;
    quarter();
  endtask
  // data moves only while scl is low; read late in the high phase
  task automatic bit_xfer(input logic b, output logic got);
    sda_low_out <= !b;
    quarter();
    scl_out <= 1'b1;
    quarter();
    quarter();
    got = sda_in;
    scl_out <= 1'b0;
    quarter();
  endtask
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], g);
    bit_xfer(1'b1, g);
    ack = !g;
  endtask
  task automatic read_byte(input logic more, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, g);
      d[i] = g;
    end
    bit_xfer(!more, g);
  endtask
endmodule
`default_nettype wire

// ===== two_wire_memory_companion_access_bench.sv
// self-checking bench for the two-wire memory companion front end
// assumes tw_host as bus master; memory kept at the smallest depth
`default_nettype none
module two_wire_memory_companion_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 512;
  logic       clk_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic [1:0] sel = 2'h0;
  logic       scl_w;
  logic       host_low;
  logic       sdo;
  logic       oe;
  wire  logic sda_w;
  int         fails = 0;
  int         comparisons = 0;
  logic [7:0] mem [DEPTH];
  logic [7:0] comp [16];
  int         ptr = 0;
  int         edges [4] = '{126, 255, 511, 383};
  logic       ak;
  logic [7:0] rd;
  // pull-up wins unless some party pulls low
  assign sda_w = !(host_low || (oe && !sdo));
  tw_host host_u (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl_w),
    .sda_low_out(host_low));
  tw_target #(.MEM_DEPTH(DEPTH)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in),
    .scl_in(scl_w), .sda_in(sda_w), .sda_out(sdo), .sda_oe_out(oe),
    .select_pin_low_in(sel[0]), .select_pin_high_in(sel[1]));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  function automatic logic [7:0] idb(input logic [3:0] id,
    input logic [1:0] s, input logic rw);
    return {id, 1'b0, s, rw};
  endfunction
  function automatic bit prot(input int a);
    case (comp[tw_pkg::PROT_REG][tw_pkg::PROT_HI:tw_pkg::PROT_LO])
      tw_pkg::PROT_QTR:  return a < DEPTH / 4;
      tw_pkg::PROT_HALF: return a < DEPTH / 2;
      tw_pkg::PROT_ALL:  return 1'b1;
      default:           return 1'b0;
    endcase
  endfunction
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic head(input logic [3:0] id, input logic [15:0] a,
    input bit two);
    host_u.start_bit();
    host_u.write_byte(idb(id, sel, 1'b0), ak);
    chk("id ack", 8'h01, {7'h0, ak});
    if (two) begin
      host_u.write_byte(a[15:8], ak);
      chk("addr hi ack", 8'h01, {7'h0, ak});
    end
    host_u.write_byte(a[7:0], ak);
    chk("addr lo ack", 8'h01, {7'h0, ak});
  endtask
  task automatic mwrite(input logic [15:0] a, input int n);
    logic [7:0] d;
    head(tw_pkg::MEM_ID, a, 1'b1);
    ptr = a % DEPTH;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      host_u.write_byte(d, ak);
      chk("write ack", 8'(!prot(ptr)), {7'h0, ak});
      if (!prot(ptr)) mem[ptr] = d;
      ptr = (ptr + 1) % DEPTH;
    end
    host_u.stop_bit();
  endtask
  // a below zero reads on from the current pointer
  task automatic mread(input int a, input int n);
    if (a >= 0) begin
      head(tw_pkg::MEM_ID, 16'(a), 1'b1);
      ptr = a % DEPTH;
    end
    host_u.start_bit();
    host_u.write_byte(idb(tw_pkg::MEM_ID, sel, 1'b1), ak);
    chk("read id ack", 8'h01, {7'h0, ak});
    for (int i = 0; i < n; i++) begin
      host_u.read_byte(i < n - 1, rd);
      chk("read data", mem[ptr], rd);
      ptr = (ptr + 1) % DEPTH;
    end
    host_u.stop_bit();
  endtask
  // single writes carry v, bursts carry random bytes
  task automatic cacc(input logic [3:0] r, input int n, input bit wr,
    input logic [7:0] v);
    logic [7:0] d;
    head(tw_pkg::COMP_ID, {12'h000, r}, 1'b0);
    if (!wr) begin
      host_u.start_bit();
      host_u.write_byte(idb(tw_pkg::COMP_ID, sel, 1'b1), ak);
      chk("comp id ack", 8'h01, {7'h0, ak});
    end
    for (int i = 0; i < n; i++) begin
      if (wr) begin
        d = (n == 1) ? v : 8'($urandom);
        host_u.write_byte(d, ak);
        chk("comp write ack", 8'h01, {7'h0, ak});
        comp[r] = d;
      end else begin
        host_u.read_byte(i < n - 1, rd);
        chk("comp read", comp[r], rd);
      end
      r = r + 4'h1;
    end
    host_u.stop_bit();
  endtask
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // about 65k cycles expected; the limit leaves some headroom
  initial begin
    #900us;
    fails++;
    $display("BAD watchdog expected end seen timeout");
    summarize();
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (comp[i]) comp[i] = tw_pkg::COMP_RST;
    void'($urandom(32'h8939));
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    sel <= 2'($urandom);
    repeat (8) @(posedge clk_in);
    chk("idle oe", 8'h00, {7'h0, oe});
    for (int s = 0; s < 4; s++) begin
      host_u.start_bit();
      host_u.write_byte(idb(tw_pkg::MEM_ID, 2'(s), 1'b0), ak);
      chk("select ack", 8'(s == sel), {7'h0, ak});
      host_u.stop_bit();
    end
    host_u.start_bit();
    host_u.write_byte(idb(4'h3, sel, 1'b0), ak);
    chk("foreign id ack", 8'h00, {7'h0, ak});
    host_u.stop_bit();
    $display("test select done");
    // reading back at once shows that writes leave no busy time
    for (int i = 0; i < 12; i++) begin
      logic [15:0] wa;
      wa = 16'($urandom);
      mwrite(wa, 1 + $urandom % 3);
      mread(($urandom % 2) ? -1 : int'(wa), 3);
    end
    $display("test random done");
    mwrite(16'h0040, 2);
    cacc(4'h0, 3, 1'b0, 8'h00);
    mread(-1, 1);
    $display("test pointer done");
    host_u.qlen = 40;
    mwrite(16'hFFFF, 2);
    mread(32'h0000FFFF, 2);
    host_u.qlen = 4;
    $display("test wrap done");
    cacc(4'h0, 16, 1'b1, 8'h00);
    cacc(4'h0, 17, 1'b0, 8'h00);
    $display("test companion done");
    for (int m = 0; m < 4; m++) begin
      cacc(tw_pkg::PROT_REG, 1, 1'b1, 8'(m << tw_pkg::PROT_LO));
      foreach (edges[j]) mwrite(16'(edges[j]), 2);
    end
    cacc(tw_pkg::PROT_REG, 1, 1'b1, 8'h00);
    foreach (edges[j]) mread(edges[j], 2);
    $display("test protect done");
    summarize();
  end
endmodule
`default_nettype wire
